// [common/uart_irq_defs.svh]
// register offsets, field positions, reset values and timing counts for the serial port interrupt block
// assumes a 32-bit word register port with byte offsets, decoded relative to the peripheral base
`ifndef UART_IRQ_DEFS_SVH
`define UART_IRQ_DEFS_SVH
`define BASE_ADDR 32'h4030_0000
`define WIN_MASK 32'hffff_ff00
`define OFF_DATA 8'h00
`define OFF_ERRSTAT 8'h04
`define OFF_IDLE 8'h0c
`define OFF_FLAG 8'h18
`define OFF_RXLC 8'h1c
`define OFF_BAUDI 8'h24
`define OFF_BAUDF 8'h28
`define OFF_TXLC 8'h2c
`define OFF_CTRL 8'h30
`define OFF_LVL 8'h34
`define OFF_MASK 8'h38
`define OFF_RAW 8'h3c
`define OFF_MSK 8'h40
`define OFF_ICLR 8'h44
`define OFF_DMA 8'h48
`define OFF_SFC 8'h50
`define OFF_RESUME_CHAR_ONE 8'h54
`define OFF_RESUME_CHAR_TWO 8'h58
`define OFF_PAUSE_CHAR_ONE 8'h5c
`define OFF_PAUSE_CHAR_TWO 8'h60
`define RST_IDLE 32'h0000_01ff
`define RST_FLAG 32'h0000_1e90
`define RST_CTRL 32'h0004_0300
`define RST_LVL 32'h0000_0012
`define RST_ZERO 32'h0000_0000
// interrupt bit positions in raw, mask, masked and clear registers
`define IB_TXE 0
`define IB_XOFF 1
`define IB_RX 2
`define IB_TX 3
`define IB_RTO 4
`define IB_ERR 5
`define NSRC 6
// error status bit positions
`define EB_FE 0
`define EB_PE 1
`define EB_BE 2
`define EB_OE 3
// control register: fifo enable bit; level select fields
`define CTRL_FEN 4
`define LVL_TX_LO 0
`define LVL_RX_LO 3
`define FIFO_DEPTH 5'h10
`endif

// [common/uart_irq_pkg.sv]
// types shared by the serial port interrupt block
// assumes the defs header supplies all numeric constants
package uart_irq_pkg;
  typedef logic [4:0] count_t; // fifo occupancy 0..16
  typedef logic [31:0] word_t; // register word
endpackage

// [hdl/reg_word_mem.sv]
// small word store for the plain read-write registers (baud, line control, dma, flow control)
// assumes one write and one read per cycle; read data comes from a register
`include "uart_irq_defs.svh"
module reg_word_mem (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic wrEn,
  input wire logic [2:0] wrIdx,
  input wire uart_irq_pkg::word_t wrData,
  input wire logic [2:0] rdIdx,
  output uart_irq_pkg::word_t rdData
);
  uart_irq_pkg::word_t mem_r [8]; // storage words
  // write port and registered read
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 8; i++) begin
        mem_r[i] <= `RST_ZERO;
      end
      rdData <= `RST_ZERO;
    end else if (ce) begin
      if (wrEn) begin
        mem_r[wrIdx] <= wrData;
      end
      rdData <= (wrEn && wrIdx == rdIdx) ? wrData : mem_r[rdIdx];
    end
  end
endmodule

// [hdl/uart_irq.sv]
// serial port register map and interrupt generation
// assumes the receiver and transmitter datapaths sit outside; they report
// fifo levels, character events and line errors as one-cycle pulses or levels
`include "uart_irq_defs.svh"

// Overview of operation
// - fifo mode rx irq at watermark
// - single mode rx irq while data held
// - fifo mode tx irq below watermark
// - single mode tx irq when location empty
// - tx irq set on transition, not level
// - accept char while holding register busy
// - bottom write clears tx irq, else software
// - timeout irq when rx idle too long
// - timeout cleared by emptying or software
// - error irq on framing parity break overrun
// - any error clear write clears flags
// - offset four reads status, writes clear
// - idle limit register resets to 511
// - decode window at fixed base address
// - four flow control character registers
// - flag control level reset values
// - six sources into one interrupt output
// - mask one enables; masked equals raw and mask
module uart_irq (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce, // freezes all state while low
  input wire logic [31:0] addr, // full byte address
  input wire logic [31:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [31:0] rdData, // valid cycle after read strobe
  input wire logic [4:0] rxCount, // receive fifo occupancy
  input wire logic [4:0] txCount, // transmit fifo occupancy (bottom location in single mode)
  input wire logic txBusy, // holding register shifting
  input wire logic rxCharPulse, // character or valid start bit seen
  input wire logic rxPopPulse, // receive data taken by the datapath
  input wire logic [7:0] rxChar, // character at top of receive fifo
  input wire logic xoffMatch, // pause or special char match pulse
  input wire logic [3:0] rxErr, // error pulses: fe pe be oe
  input wire logic [15:0] flagIn, // live flag bits from datapath
  output logic txPush, // one-cycle push of a written character
  output logic [7:0] txChar,
  output logic rxPop, // one-cycle pop request on data read
  output logic fifoEn, // fifo mode from control register
  output logic [31:0] ctrlOut,
  output logic [31:0] lvlOut,
  output logic irq // combined interrupt
);
  // register bank
  logic [31:0] idle_r; // rx idle limit
  logic [31:0] ctrl_r; // main control
  logic [31:0] lvl_r; // level select
  logic [5:0] mask_r; // interrupt mask
  logic [5:0] raw_r; // raw status
  logic [3:0] err_r; // receive error status
  logic [7:0] resume_char_one_r, resume_char_two_r, pause_char_one_r, pause_char_two_r; // flow control characters
  logic [31:0] flag_r; // flag register image
  logic [31:0] idleCnt_r; // idle counter
  logic [4:0] txCountPrev_r; // for transition detection
  logic rdPend_r; // read issued last cycle
  logic [31:0] rdMux_r; // captured read value
  logic memSel_r; // last read came from word store
  logic [31:0] memRd; // word store read data

  // address decode
  wire inWin = (addr & `WIN_MASK) == `BASE_ADDR;
  wire [7:0] off = addr[7:0];
  wire wr = wrStb && inWin;
  wire rd = rdStb && inWin;
  wire wrData0 = wr && off == `OFF_DATA;
  wire rdData0 = rd && off == `OFF_DATA;
  wire wrIcr = wr && off == `OFF_ICLR;
  wire wrEcr = wr && off == `OFF_ERRSTAT;
  wire fen = ctrl_r[`CTRL_FEN];

  // watermark from level select: code 0..4 gives 2,4,8,12,14 of 16
  function automatic logic [4:0] mark(input logic [2:0] code);
    case (code)
      3'h0: mark = 5'h02;
      3'h1: mark = 5'h04;
      3'h2: mark = 5'h08;
      3'h3: mark = 5'h0c;
      default: mark = 5'h0e;
    endcase
  endfunction

  // store index of the plain registers
  function automatic logic [2:0] memIdx(input logic [7:0] o);
    case (o)
      `OFF_RXLC: memIdx = 3'h0;
      `OFF_BAUDI: memIdx = 3'h1;
      `OFF_BAUDF: memIdx = 3'h2;
      `OFF_TXLC: memIdx = 3'h3;
      `OFF_DMA: memIdx = 3'h4;
      `OFF_SFC: memIdx = 3'h5;
      default: memIdx = 3'h7;
    endcase
  endfunction

  wire isMem = memIdx(off) != 3'h7;
  wire [4:0] rxMark = mark(lvl_r[`LVL_RX_LO +: 3]);
  wire [4:0] txMark = mark(lvl_r[`LVL_TX_LO +: 3]);

  // receive level: watermark in fifo mode, any data in single mode
  wire rxLevel = fen ? (rxCount >= rxMark) : (rxCount != 5'h00);
  // transmit: edge when the level crosses down, never on the level alone
  wire txBelow = fen ? (txCount < txMark) : (txCount == 5'h00);
  wire txBelowPrev = fen ? (txCountPrev_r < txMark) : (txCountPrev_r == 5'h00);
  wire txSet = txBelow && !txBelowPrev;
  // writes clear: above watermark, or any write into bottom location
  wire txClr = fen ? (txCount > txMark) : (txCount != 5'h00);
  wire txEmptySet = !txBusy && txCount == 5'h00 && txCountPrev_r != 5'h00;
  wire idleHit = rxCount != 5'h00 && idleCnt_r >= idle_r && idle_r != `RST_ZERO;
  wire rxEmpty = rxCount == 5'h00;

  // raw status next value: hardware set beats software clear
  logic [5:0] rawSet, rawHwClr, raw_nxt;
  always_comb begin
    rawSet = '0;
    rawHwClr = '0;
    rawSet[`IB_TXE] = txEmptySet;
    rawSet[`IB_XOFF] = xoffMatch;
    rawSet[`IB_RX] = rxLevel;
    rawHwClr[`IB_RX] = !rxLevel;
    rawSet[`IB_TX] = txSet;
    rawHwClr[`IB_TX] = txClr;
    rawSet[`IB_RTO] = idleHit;
    rawHwClr[`IB_RTO] = rxEmpty;
    rawSet[`IB_ERR] = |rxErr;
    // only ones in the clear word act
    raw_nxt = ((raw_r & ~rawHwClr) & ~(wrIcr ? wrData[5:0] : 6'h00)) | rawSet;
  end

  // error flags: sticky, any error clear write or matching clear bit
  wire [3:0] err_nxt = (err_r & ~((wrEcr || (wrIcr && wrData[`IB_ERR])) ? 4'hf : 4'h0)) | rxErr;

  // interrupt state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      raw_r <= '0;
      err_r <= '0;
      txCountPrev_r <= '0;
      idleCnt_r <= `RST_ZERO;
    end else if (ce) begin
      raw_r <= raw_nxt;
      err_r <= err_nxt;
      txCountPrev_r <= txCount;
      // idle counter restarts on a received character or empty fifo; >= recovers when the limit drops mid-count
      idleCnt_r <= (rxCharPulse || rxEmpty || idleCnt_r >= idle_r) ? `RST_ZERO : idleCnt_r + 32'h1;
    end
  end

  // software registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      idle_r <= `RST_IDLE;
      ctrl_r <= `RST_CTRL;
      lvl_r <= `RST_LVL;
      mask_r <= '0;
      resume_char_one_r <= '0;
      resume_char_two_r <= '0;
      pause_char_one_r <= '0;
      pause_char_two_r <= '0;
    end else if (ce && wr) begin
      case (off)
        `OFF_IDLE: idle_r <= wrData;
        `OFF_CTRL: ctrl_r <= wrData;
        `OFF_LVL: lvl_r <= wrData;
        `OFF_MASK: mask_r <= wrData[5:0];
        `OFF_RESUME_CHAR_ONE: resume_char_one_r <= wrData[7:0];
        `OFF_RESUME_CHAR_TWO: resume_char_two_r <= wrData[7:0];
        `OFF_PAUSE_CHAR_ONE: pause_char_one_r <= wrData[7:0];
        `OFF_PAUSE_CHAR_TWO: pause_char_two_r <= wrData[7:0];
        default: begin
        end
      endcase
    end
  end

  reg_word_mem u_mem (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .wrEn(wr && isMem),
    .wrIdx(memIdx(off)),
    .wrData(wrData),
    .rdIdx(memIdx(off)),
    .rdData(memRd)
  );

  // read selection
  wire [5:0] masked_interrupt_status = raw_r & mask_r;
  logic [31:0] rdSel;
  always_comb begin
    case (off)
      `OFF_DATA: rdSel = {20'h0, err_r, rxChar};
      `OFF_ERRSTAT: rdSel = {28'h0, err_r};
      `OFF_IDLE: rdSel = idle_r;
      `OFF_FLAG: rdSel = flag_r;
      `OFF_CTRL: rdSel = ctrl_r;
      `OFF_LVL: rdSel = lvl_r;
      `OFF_MASK: rdSel = {26'h0, mask_r};
      `OFF_RAW: rdSel = {26'h0, raw_r};
      `OFF_MSK: rdSel = {26'h0, masked_interrupt_status};
      `OFF_RESUME_CHAR_ONE: rdSel = {24'h0, resume_char_one_r};
      `OFF_RESUME_CHAR_TWO: rdSel = {24'h0, resume_char_two_r};
      `OFF_PAUSE_CHAR_ONE: rdSel = {24'h0, pause_char_one_r};
      `OFF_PAUSE_CHAR_TWO: rdSel = {24'h0, pause_char_two_r};
      default: rdSel = `RST_ZERO;
    endcase
  end

  // read pipeline and data port side effects
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdMux_r <= `RST_ZERO;
      memSel_r <= 1'b0;
      rdPend_r <= 1'b0;
      flag_r <= `RST_FLAG;
      txPush <= 1'b0;
      txChar <= 8'h00;
      rxPop <= 1'b0;
      irq <= 1'b0;
      fifoEn <= 1'b0;
      ctrlOut <= `RST_CTRL;
      lvlOut <= `RST_LVL;
    end else if (ce) begin
      rdMux_r <= rd ? rdSel : `RST_ZERO;
      memSel_r <= rd && isMem;
      rdPend_r <= rd;
      flag_r <= {16'h0, flagIn};
      // holding register may be busy: the write goes into the bottom location
      txPush <= wrData0;
      txChar <= wrData0 ? wrData[7:0] : txChar;
      rxPop <= rdData0;
      irq <= |masked_interrupt_status;
      fifoEn <= fen;
      ctrlOut <= ctrl_r;
      lvlOut <= lvl_r;
    end
  end

  assign rdData = memSel_r ? memRd : rdMux_r;

  // assertions
  property p_rx_single;
    @(posedge clk) disable iff (!rst_b) ce && !fen && rxCount != 5'h00 |=> raw_r[`IB_RX];
  endproperty
  a_rx_single: assert property (p_rx_single) else $error("rx irq missing in single mode");

  property p_rx_fifo;
    @(posedge clk) disable iff (!rst_b) ce && fen && rxCount >= rxMark |=> raw_r[`IB_RX];
  endproperty
  a_rx_fifo: assert property (p_rx_fifo) else $error("rx irq missing at watermark");

  property p_tx_edge;
    @(posedge clk) disable iff (!rst_b) ce && !txSet && !raw_r[`IB_TX] |=> !raw_r[`IB_TX];
  endproperty
  a_tx_edge: assert property (p_tx_edge) else $error("tx irq set without transition");

  property p_tx_clr;
    @(posedge clk) disable iff (!rst_b) ce && txClr && !txSet |=> !raw_r[`IB_TX];
  endproperty
  a_tx_clr: assert property (p_tx_clr) else $error("tx irq not cleared by write");

  property p_err_sticky;
    @(posedge clk) disable iff (!rst_b) ce && err_r[`EB_FE] && !wrEcr && !(wrIcr && wrData[`IB_ERR]) |=> err_r[`EB_FE];
  endproperty
  a_err_sticky: assert property (p_err_sticky) else $error("error flag dropped");

  property p_ecr;
    @(posedge clk) disable iff (!rst_b) ce && wrEcr && rxErr == 4'h0 |=> err_r == 4'h0;
  endproperty
  a_ecr: assert property (p_ecr) else $error("error clear write ignored");

  property p_irq;
    @(posedge clk) disable iff (!rst_b) ce |=> irq == |$past(masked_interrupt_status);
  endproperty
  a_irq: assert property (p_irq) else $error("irq does not follow masked status");

  property p_rto_clr;
    @(posedge clk) disable iff (!rst_b) ce && rxEmpty && !idleHit |=> !raw_r[`IB_RTO];
  endproperty
  a_rto_clr: assert property (p_rto_clr) else $error("timeout irq not cleared");

  // a pending error stays raised while its clear bit is written as zero
  property p_icr_zero;
    @(posedge clk) disable iff (!rst_b) ce && wrIcr && !wrData[`IB_ERR] && raw_r[`IB_ERR] |=> raw_r[`IB_ERR];
  endproperty
  a_icr_zero: assert property (p_icr_zero) else $error("zero clear bit had effect");

  property p_rto_set;
    @(posedge clk) disable iff (!rst_b) ce && idleHit |=> raw_r[`IB_RTO];
  endproperty
  a_rto_set: assert property (p_rto_set) else $error("timeout irq missing");

  property p_tx_set;
    @(posedge clk) disable iff (!rst_b) ce && txSet |=> raw_r[`IB_TX];
  endproperty
  a_tx_set: assert property (p_tx_set) else $error("tx irq missing after transition");

  property p_err_set;
    @(posedge clk) disable iff (!rst_b) ce && rxErr != 4'h0 |=> raw_r[`IB_ERR];
  endproperty
  a_err_set: assert property (p_err_set) else $error("error irq missing");

  property p_icr_one;
    @(posedge clk) disable iff (!rst_b) ce && wrIcr && wrData[`IB_ERR] && rxErr == 4'h0
      |=> !raw_r[`IB_ERR] && err_r == 4'h0;
  endproperty
  a_icr_one: assert property (p_icr_one) else $error("error irq not cleared by clear bit");

  property p_mis_rd;
    @(posedge clk) disable iff (!rst_b) ce && rd && off == `OFF_MSK |=> rdData == {26'h0, $past(masked_interrupt_status)};
  endproperty
  a_mis_rd: assert property (p_mis_rd) else $error("masked status read wrong");

  property p_win;
    @(posedge clk) disable iff (!rst_b) ce && rdStb && !inWin |=> !rdPend_r && rdData == `RST_ZERO;
  endproperty
  a_win: assert property (p_win) else $error("read outside window answered");

  property p_idle_wr;
    @(posedge clk) disable iff (!rst_b) ce && wr && off == `OFF_IDLE |=> idle_r == $past(wrData);
  endproperty
  a_idle_wr: assert property (p_idle_wr) else $error("idle limit write lost");

  property p_errstat_rd;
    @(posedge clk) disable iff (!rst_b) ce && rd && off == `OFF_ERRSTAT |=> rdData == {28'h0, $past(err_r)};
  endproperty
  a_errstat_rd: assert property (p_errstat_rd) else $error("error status read wrong");

  property p_tx_push;
    @(posedge clk) disable iff (!rst_b) ce && wrData0 |=> txPush;
  endproperty
  a_tx_push: assert property (p_tx_push) else $error("data write not pushed");

  property p_mask_wr;
    @(posedge clk) disable iff (!rst_b) ce && wr && off == `OFF_MASK |=> mask_r == $past(wrData[5:0]);
  endproperty
  a_mask_wr: assert property (p_mask_wr) else $error("mask write lost");

  c_rx: cover property (@(posedge clk) disable iff (!rst_b) raw_r[`IB_RX] ##1 !raw_r[`IB_RX]);
  c_tx: cover property (@(posedge clk) disable iff (!rst_b) txSet);
  c_rto: cover property (@(posedge clk) disable iff (!rst_b) idleHit);
  c_irq: cover property (@(posedge clk) disable iff (!rst_b) irq);
  c_err: cover property (@(posedge clk) disable iff (!rst_b) raw_r[`IB_ERR]);
endmodule

// [sim/line_side_model.sv]
// stand-in for the receive and transmit datapath between the block and the line
// assumes the bench pulses rxAdd, txDrain and errIn one cycle at a time
module line_side_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic txPush, // character written by software
  input wire logic rxPop, // character read by software
  input wire logic rxAdd, // a character arrives from the line
  input wire logic txDrain, // a character leaves for the line
  input wire logic [3:0] errIn, // line error seen by the bench
  output logic [4:0] rxCount,
  output logic [4:0] txCount,
  output logic txBusy,
  output logic rxCharPulse,
  output logic [3:0] rxErr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic popOk; // never pop an empty fifo
  logic drainOk; // never drain an empty fifo
  assign popOk = rxPop && (rxCount != 5'h00);
  assign drainOk = txDrain && (txCount != 5'h00);
  assign txBusy = txCount != 5'h00;
  // occupancy counters and one-cycle event pulses
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rxCount <= 5'h00;
      txCount <= 5'h00;
      rxCharPulse <= 1'b0;
      rxErr <= 4'h0;
    end else begin
      rxCount <= rxCount + 5'(rxAdd) - 5'(popOk);
      txCount <= txCount + 5'(txPush) - 5'(drainOk);
      rxCharPulse <= rxAdd;
      rxErr <= errIn;
    end
  end
endmodule

// [sim/tb_uart_irq.sv]
// self-checking bench for the serial port register map and interrupts
// assumes the line model supplies fifo levels and events; ce held high except for one write in the freeze check
`include "uart_irq_defs.svh"
module tb_uart_irq;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [7:0] o; logic w; logic [31:0] d; logic [31:0] e;} row_s;
  logic clk, rst_b, ce, wrStb, rdStb, rxAdd, txDrain, txPush, rxPop, irq, fifoEn;
  logic [7:0] txChar;
  logic [31:0] ctrlOut, lvlOut;
  logic [31:0] addr, wrData, rdData, v;
  logic [4:0] rxCount, txCount;
  logic txBusy, rxCharPulse;
  logic [3:0] errIn, rxErr;
  int fails, checks_done;
  // offset, write flag, write value, expected read
  row_s rows[12] = '{'{8'h0c, 1'b0, 32'h0, 32'h1ff}, '{8'h30, 1'b0, 32'h0, 32'h40300},
    '{8'h34, 1'b0, 32'h0, 32'h12}, '{8'h18, 1'b0, 32'h0, 32'h1e90}, '{8'h38, 1'b0, 32'h0, 32'h0},
    '{8'h40, 1'b0, 32'h0, 32'h0}, '{8'h54, 1'b1, 32'h11, 32'h11}, '{8'h58, 1'b1, 32'h22, 32'h22},
    '{8'h5c, 1'b1, 32'h33, 32'h33}, '{8'h60, 1'b1, 32'h44, 32'h44}, '{8'h24, 1'b1, 32'h5a, 32'h5a},
    '{8'h08, 1'b1, 32'hff, 32'h0}};
  uart_irq dut_u (.clk(clk), .rst_b(rst_b), .ce(ce), .addr(addr), .wrData(wrData), .wrStb(wrStb),
    .rdStb(rdStb), .rdData(rdData), .rxCount(rxCount), .txCount(txCount), .txBusy(txBusy),
    .rxCharPulse(rxCharPulse), .rxPopPulse(1'b0), .rxChar(8'h41), .xoffMatch(1'b0), .rxErr(rxErr),
    .flagIn(16'h1e90), .txPush(txPush), .txChar(txChar), .rxPop(rxPop), .fifoEn(fifoEn),
    .ctrlOut(ctrlOut), .lvlOut(lvlOut), .irq(irq));
  line_side_model line_u (.clk(clk), .rst_b(rst_b), .txPush(txPush), .rxPop(rxPop), .rxAdd(rxAdd),
    .txDrain(txDrain), .errIn(errIn), .rxCount(rxCount), .txCount(txCount), .txBusy(txBusy),
    .rxCharPulse(rxCharPulse), .rxErr(rxErr));
  // free-running clock at 50 ns
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // compare and count
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // one-cycle write strobe at a full address
  task wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge clk);
    wrStb <= 1'b0;
  endtask
  // one-cycle read strobe, data taken in the following cycle
  task rd(input logic [31:0] a);
    @(posedge clk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge clk);
    rdStb <= 1'b0;
    #1 v = rdData;
  endtask
  task idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  // characters arriving from the line
  task rx_in(input int n);
    repeat (n) begin
      @(posedge clk) rxAdd <= 1'b1;
      @(posedge clk) rxAdd <= 1'b0;
    end
  endtask
  task stop_test;
    if (fails == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // main sequence
  initial begin
    fails = 0;
    checks_done = 0;
    {rst_b, wrStb, rdStb, rxAdd, txDrain, errIn} = '0;
    ce = 1'b1;
    addr = `BASE_ADDR;
    wrData = '0;
    idle(20);
    rst_b <= 1'b1;
    rd(`BASE_ADDR | 32'h3c);
    chk("tx irq idle", v & 32'h08, 32'h0);
    chk("ctrl out", ctrlOut, 32'h40300);
    chk("lvl out", lvlOut, 32'h12);
    foreach (rows[i]) begin
      if (rows[i].w) wr(`BASE_ADDR | rows[i].o, rows[i].d);
      rd(`BASE_ADDR | rows[i].o);
      chk("reg row", v, rows[i].e);
    end
    wr(`BASE_ADDR | 32'h154, 32'hff);
    rd(`BASE_ADDR | 32'h54);
    chk("outside window", v, 32'h11);
    rd(`BASE_ADDR | 32'h154);
    chk("outside read", v, 32'h0);
    // line error: sticky, masked, cleared
    @(posedge clk) errIn <= 4'h1;
    @(posedge clk) errIn <= 4'h0;
    rd(`BASE_ADDR | 32'h04);
    chk("err status", v, 32'h1);
    wr(`BASE_ADDR | 32'h38, 32'h20);
    idle(3);
    chk("irq err", {31'h0, irq}, 32'h1);
    rd(`BASE_ADDR | 32'h40);
    chk("masked", v, 32'h20);
    wr(`BASE_ADDR | 32'h44, 32'h0);
    wr(`BASE_ADDR | 32'h04, 32'h0);
    rd(`BASE_ADDR | 32'h04);
    chk("err cleared", v, 32'h0);
    rd(`BASE_ADDR | 32'h3c);
    chk("raw err kept", v & 32'h20, 32'h20);
    wr(`BASE_ADDR | 32'h44, 32'h20);
    idle(3);
    chk("irq err off", {31'h0, irq}, 32'h0);
    // fifo mode receive watermark of 8
    wr(`BASE_ADDR | 32'h30, 32'h40310);
    rx_in(8);
    idle(2);
    rd(`BASE_ADDR | 32'h3c);
    chk("rx at mark", v & 32'h04, 32'h04);
    chk("fifo mode", {31'h0, fifoEn}, 32'h1);
    rd(`BASE_ADDR | 32'h00);
    idle(3);
    rd(`BASE_ADDR | 32'h3c);
    chk("rx below mark", v & 32'h04, 32'h0);
    // idle timeout with short limit, bounded wait on irq
    wr(`BASE_ADDR | 32'h0c, 32'h10);
    wr(`BASE_ADDR | 32'h38, 32'h10);
    for (int k = 0; k < 60 && irq !== 1'b1; k++) @(posedge clk);
    if (irq !== 1'b1) begin
      fails++;
      stop_test();
    end
    repeat (7) rd(`BASE_ADDR | 32'h00);
    idle(3);
    rd(`BASE_ADDR | 32'h3c);
    chk("timeout off", v & 32'h10, 32'h0);
    // single location mode
    wr(`BASE_ADDR | 32'h30, 32'h40300);
    rx_in(1);
    idle(2);
    rd(`BASE_ADDR | 32'h3c);
    chk("rx single", v & 32'h04, 32'h04);
    rd(`BASE_ADDR | 32'h00);
    idle(3);
    rd(`BASE_ADDR | 32'h3c);
    chk("rx single off", v & 32'h04, 32'h0);
    wr(`BASE_ADDR | 32'h00, 32'h41);
    @(posedge clk) txDrain <= 1'b1;
    @(posedge clk) txDrain <= 1'b0;
    idle(3);
    rd(`BASE_ADDR | 32'h3c);
    chk("tx empty", v & 32'h08, 32'h08);
    chk("tx char", {24'h0, txChar}, 32'h41);
    wr(`BASE_ADDR | 32'h00, 32'h42);
    idle(3);
    rd(`BASE_ADDR | 32'h3c);
    chk("tx refilled", v & 32'h08, 32'h0);
    // clock enable low: a register write is ignored
    @(posedge clk) ce <= 1'b0;
    wr(`BASE_ADDR | 32'h0c, 32'h33);
    ce <= 1'b1;
    rd(`BASE_ADDR | 32'h0c);
    chk("ce freeze", v, 32'h10);
    // reset in mid-run: registers return to their reset values
    @(posedge clk) rst_b <= 1'b0;
    idle(2);
    chk("rst rd", rdData, 32'h0);
    chk("rst irq", {31'h0, irq}, 32'h0);
    chk("rst ctrl", ctrlOut, 32'h40300);
    rst_b <= 1'b1;
    rd(`BASE_ADDR | 32'h0c);
    chk("rst idle", v, 32'h1ff);
    rd(`BASE_ADDR | 32'h54);
    chk("rst xon", v, 32'h0);
    rd(`BASE_ADDR | 32'h38);
    chk("rst mask", v, 32'h0);
    stop_test();
  end
endmodule
